// [testbench/tbc_evt_src.sv]
// Event routing stand-in: count pulses, direction level, restart
`default_nettype none
module tbc_evt_src (
  // Clock
  input  wire logic clk,
  // Event lines to the timer
  output var logic  evt_count,
  output var logic  evt_dir,
  output var logic  evt_restart
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet lines from time zero
  initial begin
    evt_count   = 1'b0;
    evt_dir     = 1'b0;
    evt_restart = 1'b0;
  end
  // One-cycle count pulses, gap sets how slowly they come
  task automatic pulse_count(input int n, input int gap);
    repeat (n) begin
      @(posedge clk);
      evt_count <= 1'b1;
      @(posedge clk);
      evt_count <= 1'b0;
      repeat (gap) @(posedge clk);
    end
  endtask : pulse_count
  // Direction level, one means down
  task automatic set_dir(input logic d);
    @(posedge clk);
    evt_dir <= d;
  endtask : set_dir
  // Single restart pulse
  task automatic pulse_restart();
    @(posedge clk);
    evt_restart <= 1'b1;
    @(posedge clk);
    evt_restart <= 1'b0;
  endtask : pulse_restart
endmodule : tbc_evt_src
`default_nettype wire

// [testbench/tbc_timer_base_counter_asserts.sv]
// Port checker for the timer base counter, bound to its top module
`default_nettype none
`include "tbc_consts.svh"
module tbc_asserts (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RESET,
  // Register bus
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  // Events
  input wire logic        EVT_COUNT,
  input wire logic        PEAK_EVT,
  input wire logic        ZERO_EVT,
  input wire logic [2:0]  MATCH_EVT,
  input wire logic [2:0]  MATCH_HI_EVT
);
  logic wr_lo;   // Low-lane write lands this edge
  logic en_q;    // Shadow of enable
  logic evc_q;   // Shadow of event count enable
  logic split_q; // Shadow of split mode
  assign wr_lo = WB_ACK_O & WB_CYC_I & WB_STB_I & WB_WE_I & WB_SEL_I[0];
  // Shadows land on the same edge as the real registers
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      en_q    <= 1'b0;
      evc_q   <= 1'b0;
      split_q <= 1'b0;
    end else if (wr_lo) begin
      en_q    <= (WB_ADR_I == `TBC_OFS_CONTROL_A_REG) ? WB_DAT_I[`TBC_A_ENABLE] : en_q;
      evc_q   <= (WB_ADR_I == `TBC_OFS_EVENT_CONTROL_REG) ? WB_DAT_I[`TBC_EV_COUNT_EN] : evc_q;
      split_q <= (WB_ADR_I == `TBC_OFS_CTRLB) ? WB_DAT_I[`TBC_B_SPLIT] : split_q;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  ////////////////////////////////////////////////////////////////
  ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack stood longer than one cycle");
  ack_answer_a: assert property ($rose(WB_CYC_I && WB_STB_I) |=> WB_ACK_O)
    else $error("ack missing one cycle after request");
  ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  unmapped_zero_a: assert property ((WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h40) |-> WB_DAT_O == 32'h0000_0000)
    else $error("unmapped read not zero");
  control_a_reg_upper_a: assert property ((WB_ACK_O && !WB_WE_I && WB_ADR_I == `TBC_OFS_CONTROL_A_REG)
    |-> WB_DAT_O[31:4] == 28'h000_0000) else $error("control upper bits not zero");
  idle_quiet_a: assert property ($past(!en_q) |-> !PEAK_EVT && !ZERO_EVT && MATCH_EVT == 3'h0)
    else $error("event while disabled");
  event_gate_a: assert property ($past(en_q && evc_q && !EVT_COUNT) |-> !PEAK_EVT && !ZERO_EVT)
    else $error("event without count event");
  split_only_a: assert property ($past(!split_q) |-> MATCH_HI_EVT == 3'h0)
    else $error("upper match outside split mode");
  cover property (PEAK_EVT);
  cover property (ZERO_EVT);
  cover property (WB_ACK_O && !WB_WE_I);
endmodule : tbc_asserts
bind tbc_timer_base_counter tbc_asserts tbc_asserts_inst (
  .CLK(CLK), .RESET(RESET), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .EVT_COUNT(EVT_COUNT), .PEAK_EVT(PEAK_EVT),
  .ZERO_EVT(ZERO_EVT), .MATCH_EVT(MATCH_EVT), .MATCH_HI_EVT(MATCH_HI_EVT)
);
`default_nettype wire

// [testbench/tbc_timer_base_counter_bench.sv]
// Self-checking bench for the timer base counter
`default_nettype none
`include "tbc_consts.svh"
module tbc_timer_base_counter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, reset;       // Clock and reset
  logic        cyc, stb, we;     // Bus control
  logic [7:0]  adr;              // Byte address
  logic [3:0]  sel;              // Byte lanes
  logic [31:0] dat_w, dat_r;     // Bus data
  logic        ack;              // Acknowledge
  logic        ev_cnt, ev_dir;   // Partner events
  logic        ev_rst;           // Partner restart
  logic        peak, zero;       // Event pulses
  logic [2:0]  mat, mat_hi;      // Match pulses
  int          mismatches;       // Failed compares
  int          num_checks;       // All compares
  int          peaks;            // Peak pulses seen
  int          hi_seen;          // All-channel upper match pulses seen
  tbc_timer_base_counter tbc_timer_base_counter_inst (
    .CLK(clk), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
    .EVT_COUNT(ev_cnt), .EVT_DIR(ev_dir), .EVT_RESTART(ev_rst), .PEAK_EVT(peak),
    .ZERO_EVT(zero), .MATCH_EVT(mat), .MATCH_HI_EVT(mat_hi));
  tbc_evt_src tbc_evt_src_inst (.clk(clk), .evt_count(ev_cnt), .evt_dir(ev_dir), .evt_restart(ev_rst));
  // 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Count peak pulses
  always @(posedge clk) peaks <= (peak === 1'b1) ? peaks + 1 : peaks;
  // Count upper-half match pulses on all three channels at once
  always @(posedge clk) hi_seen <= (mat_hi === 3'b111) ? hi_seen + 1 : hi_seen;
  // Run needs a few hundred cycles; this is far beyond
  initial begin
    #200000;
    mismatches++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////
  // Classic cycle; data taken at the acknowledging edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat_w} <= {2'b11, w, a, 4'h3, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_r;
    // A missing answer counts as a failure, not a silent pass
    if (ack !== 1'b1) begin
      mismatches++;
      $display("wrong value bus ack: expected 1, seen %b", ack);
    end
    {cyc, stb} <= 2'b00;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  // Read a register and compare
  task automatic expect_reg(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(nm, e, q);
  endtask : expect_reg
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////
  // Reset values and an unmapped place
  task automatic t_reset();
    expect_reg("count", `TBC_OFS_COUNT, 32'h0000_0000);
    expect_reg("wrap", `TBC_OFS_WRAP, 32'h0000_FFFF);
    expect_reg("wrapbuf", `TBC_OFS_WRAPBUF, 32'h0000_FFFF);
    expect_reg("valid", `TBC_OFS_CONTROL_F_REG, 32'h0000_0000);
    expect_reg("unmapped", 8'h40, 32'h0000_0000);
    expect_reg("control_a_reg", `TBC_OFS_CONTROL_A_REG, 32'h0000_0000);
  endtask : t_reset
  // Event counting up through the peak, then down through zero
  task automatic t_events();
    wr(`TBC_OFS_WRAP, 32'h0000_0003);
    wr(`TBC_OFS_EVENT_CONTROL_REG, 32'h0000_0001);
    wr(`TBC_OFS_CONTROL_A_REG, 32'h0000_0001);
    peaks = 0;
    tbc_evt_src_inst.pulse_count(5, 0);
    expect_reg("up wrap", `TBC_OFS_COUNT, 32'h0000_0001);
    chk("peak pulses", 32'h0000_0001, peaks);
    wr(`TBC_OFS_CONTROL_E_REG, 32'h0000_0001);
    tbc_evt_src_inst.pulse_count(3, 2);
    expect_reg("down reload", `TBC_OFS_COUNT, 32'h0000_0002);
    wr(`TBC_OFS_CONTROL_E_REG, 32'h0000_0000);
    wr(`TBC_OFS_EVENT_CONTROL_REG, 32'h0000_0003);
    tbc_evt_src_inst.set_dir(1'b1);
    tbc_evt_src_inst.pulse_count(1, 0);
    expect_reg("event dir", `TBC_OFS_COUNT, 32'h0000_0001);
    tbc_evt_src_inst.set_dir(1'b0);
    wr(`TBC_OFS_EVENT_CONTROL_REG, 32'h0000_0005);
    tbc_evt_src_inst.pulse_restart();
    expect_reg("restart", `TBC_OFS_COUNT, 32'h0000_0000);
    wr(`TBC_OFS_EVENT_CONTROL_REG, 32'h0000_0001);
  endtask : t_events
  // Buffered limit moves only at the zero point, hold blocks it
  task automatic t_buffer();
    wr(`TBC_OFS_COUNT, 32'h0000_1234);
    expect_reg("count write", `TBC_OFS_COUNT, 32'h0000_1234);
    wr(`TBC_OFS_COUNT, 32'h0000_0003);
    wr(`TBC_OFS_MATCH, 32'h0000_0005);
    wr(`TBC_OFS_WRAPBUF, 32'h0000_0002);
    expect_reg("valid set", `TBC_OFS_CONTROL_F_REG, 32'h0000_0001);
    expect_reg("wrap kept", `TBC_OFS_WRAP, 32'h0000_0003);
    tbc_evt_src_inst.pulse_count(2, 1);
    expect_reg("wrap moved", `TBC_OFS_WRAP, 32'h0000_0002);
    expect_reg("valid clear", `TBC_OFS_CONTROL_F_REG, 32'h0000_0000);
    expect_reg("match kept", `TBC_OFS_MATCH, 32'h0000_0005);
    expect_reg("match buffer", `TBC_OFS_MATCHBUF, 32'h0000_0000);
    wr(`TBC_OFS_CONTROL_E_REG, 32'h0000_0002);
    wr(`TBC_OFS_WRAPBUF, 32'h0000_0007);
    tbc_evt_src_inst.pulse_count(3, 0);
    expect_reg("held wrap", `TBC_OFS_WRAP, 32'h0000_0002);
    expect_reg("held valid", `TBC_OFS_CONTROL_F_REG, 32'h0000_0001);
    wr(`TBC_OFS_CONTROL_E_REG, 32'h0000_0000);
    tbc_evt_src_inst.pulse_count(3, 0);
    expect_reg("released", `TBC_OFS_WRAP, 32'h0000_0007);
  endtask : t_buffer
  // Direct limit below the count, then run at the clock rate
  task automatic t_direct();
    wr(`TBC_OFS_COUNT, 32'h0000_000A);
    wr(`TBC_OFS_WRAP, 32'h0000_0004);
    expect_reg("direct wrap", `TBC_OFS_WRAP, 32'h0000_0004);
    tbc_evt_src_inst.pulse_count(1, 0);
    expect_reg("past limit", `TBC_OFS_COUNT, 32'h0000_000B);
    wr(`TBC_OFS_COUNT, 32'h0000_FFFF);
    tbc_evt_src_inst.pulse_count(1, 0);
    expect_reg("all ones", `TBC_OFS_COUNT, 32'h0000_0000);
    wr(`TBC_OFS_CONTROL_A_REG, 32'h0000_0000);
    wr(`TBC_OFS_EVENT_CONTROL_REG, 32'h0000_0000);
    wr(`TBC_OFS_WRAP, 32'h0000_FFFF);
    wr(`TBC_OFS_CONTROL_A_REG, 32'h0000_0001);
    wr(`TBC_OFS_CONTROL_A_REG, 32'h0000_0000);
    expect_reg("clock ticks", `TBC_OFS_COUNT, 32'h0000_0003);
  endtask : t_direct
  // Sticky hit flags, then split mode halves
  task automatic t_status();
    wr(`TBC_OFS_EVENT_CONTROL_REG, 32'h0000_0001);
    wr(`TBC_OFS_CONTROL_A_REG, 32'h0000_0001);
    wr(`TBC_OFS_STATUS, 32'h0000_001F);
    expect_reg("status clear", `TBC_OFS_STATUS, 32'h0000_0000);
    wr(`TBC_OFS_COUNT, 32'h0000_0005);
    tbc_evt_src_inst.pulse_count(1, 0);
    expect_reg("match flag", `TBC_OFS_STATUS, 32'h0000_0004);
    wr(`TBC_OFS_STATUS, 32'h0000_001F);
    wr(`TBC_OFS_COUNT, 32'h0000_0000);
    tbc_evt_src_inst.pulse_count(1, 0);
    expect_reg("zero flags", `TBC_OFS_STATUS, 32'h0000_001A);
    wr(`TBC_OFS_STATUS, 32'h0000_001F);
    wr(`TBC_OFS_CTRLB, 32'h0000_0002);
    wr(`TBC_OFS_COUNT, 32'h0000_0005);
    tbc_evt_src_inst.pulse_count(1, 0);
    expect_reg("split count", `TBC_OFS_COUNT, 32'h0000_FF04);
    chk("upper matches", 32'h0000_0001, hi_seen);
    expect_reg("split flags", `TBC_OFS_STATUS, 32'h0000_0005);
  endtask : t_status
  // Main sequence
  initial begin
    {reset, cyc, stb, we, adr, sel, dat_w} = {1'b1, 47'h0};
    {mismatches, num_checks, peaks, hi_seen} = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_events();
    t_buffer();
    t_direct();
    t_status();
    end_sim();
  end
endmodule : tbc_timer_base_counter_bench
`default_nettype wire

// [verilog/tbc_consts.svh]
// Offsets, field positions, reset values and fixed points of the timer base counter
`ifndef TBC_CONSTS_SVH
`define TBC_CONSTS_SVH
// Register byte offsets on the bus
`define TBC_OFS_CONTROL_A_REG    8'h00
`define TBC_OFS_CTRLB    8'h04
`define TBC_OFS_CONTROL_E_REG    8'h08
`define TBC_OFS_CONTROL_F_REG    8'h0C
`define TBC_OFS_EVENT_CONTROL_REG   8'h10
`define TBC_OFS_STATUS   8'h14
`define TBC_OFS_COUNT    8'h18
`define TBC_OFS_WRAP     8'h1C
`define TBC_OFS_WRAPBUF  8'h20
`define TBC_OFS_MATCH    8'h24
`define TBC_OFS_MATCHBUF 8'h30
`define TBC_OFS_STRIDE   8'h04
// Control A fields
`define TBC_A_ENABLE     0
`define TBC_A_PRESC_LO   1
`define TBC_A_PRESC_HI   3
// Control B fields
`define TBC_B_UPD_PEAK   0
`define TBC_B_SPLIT      1
// Control E fields
`define TBC_E_DIR        0
`define TBC_E_HOLD       1
// Control F fields: wrap valid, then match valids
`define TBC_F_WRAP_BV    0
`define TBC_F_MATCH_BV   1
// Event control fields
`define TBC_EV_COUNT_EN  0
`define TBC_EV_DIR_EN    1
`define TBC_EV_RESTART   2
// Status flag fields
`define TBC_S_PEAK       0
`define TBC_S_ZERO       1
`define TBC_S_MATCH      2
// Reset values and fixed points
`define TBC_RST_WORD     16'h0000
`define TBC_RST_WRAP     16'hFFFF
`define TBC_ZERO_POINT   16'h0000
`define TBC_ALL_ONES     16'hFFFF
`define TBC_RST_BYTE     8'h00
`define TBC_RST_BUS      32'h0000_0000
`endif

// [verilog/tbc_pkg.sv]
// Types shared by the timer base counter
`default_nettype none
package tbc_pkg;
  typedef logic [15:0] tbc_word_t;    // Counter width value
  typedef logic [7:0]  tbc_byte_t;    // Split half width value
  typedef enum logic [1:0] {
    TBC_UP   = 2'b01,
    TBC_DOWN = 2'b10
  } tbc_dir_t;                        // Count direction
endpackage : tbc_pkg
`default_nettype wire

// [verilog/tbc_timer_base_counter.sv]
// Timer base counter with double-buffered wrap limit and match values, Wishbone slave
//
// Contract
// - Count, limit, matches, buffers are 16 bits.
// - Every buffer has its own valid flag.
// - Count compared with zero, limit, matches.
// - Hit effects appear on following timer tick.
// - Tick from prescaled clock or events.
// - Zero point is 0x0000; peak is limit.
// - Transfer point loads valid buffers unless held or in split mode.
// - Enable bit starts counting at prescale rate.
// - Event count enable counts event A.
// - Normal count direction from control E.
// - Up at peak wraps to zero.
// - Down at zero reloads wrap limit.
// - Count write immediate, beats count/reload.
// - Direction changes accepted while running.
// - Buffer write sets valid; transfer clears.
// - Match and buffer both software accessible.
// - Direct wrap limit write is immediate.
// - Limit below count: run to all-ones.
// - Buffered limit changes only at transfer.
// - Split mode: two 8-bit counters.
// - Events steer direction and restart counter.
`include "tbc_consts.svh"
`default_nettype none
module tbc_timer_base_counter
  import tbc_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET,
  // Wishbone classic slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Event inputs, synchronous to CLK
  input  wire logic        EVT_COUNT,
  input  wire logic        EVT_DIR,
  input  wire logic        EVT_RESTART,
  // Event outputs, one-cycle pulses
  output logic             PEAK_EVT,
  output logic             ZERO_EVT,
  output logic      [2:0]  MATCH_EVT,
  output logic      [2:0]  MATCH_HI_EVT
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end

  logic        ack_q;                 // Registered acknowledge
  logic [31:0] rd_q;                  // Registered read data
  logic [31:0] rd_mux;                // Selected read word
  wire         bus_req = WB_CYC_I & WB_STB_I;
  // Write lands at the edge where the master sees ack
  wire         wr = bus_req & ack_q & WB_WE_I;
  wire         lane0 = WB_SEL_I[0];

  // Decoded selects
  wire sel_a    = WB_ADR_I == `TBC_OFS_CONTROL_A_REG;
  wire sel_b    = WB_ADR_I == `TBC_OFS_CTRLB;
  wire sel_e    = WB_ADR_I == `TBC_OFS_CONTROL_E_REG;
  wire sel_f    = WB_ADR_I == `TBC_OFS_CONTROL_F_REG;
  wire sel_ev   = WB_ADR_I == `TBC_OFS_EVENT_CONTROL_REG;
  wire sel_st   = WB_ADR_I == `TBC_OFS_STATUS;
  wire sel_cnt  = WB_ADR_I == `TBC_OFS_COUNT;
  wire sel_wrap = WB_ADR_I == `TBC_OFS_WRAP;
  wire sel_wbuf = WB_ADR_I == `TBC_OFS_WRAPBUF;

  // Write strobes
  wire we_a    = wr & sel_a & lane0;
  wire we_b    = wr & sel_b & lane0;
  wire we_e    = wr & sel_e & lane0;
  wire we_ev   = wr & sel_ev & lane0;
  wire we_st   = wr & sel_st & lane0;
  wire we_cnt  = wr & sel_cnt;
  wire we_wrap = wr & sel_wrap;
  wire we_wbuf = wr & sel_wbuf;

  // Byte-lane merge of a 16-bit register
  function automatic tbc_word_t tbc_merge(input tbc_word_t old, input logic [31:0] d,
                                          input logic [3:0] s);
    tbc_word_t r;
    r[15:8] = s[1] ? d[15:8] : old[15:8];
    r[7:0]  = s[0] ? d[7:0] : old[7:0];
    return r;
  endfunction : tbc_merge

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  tbc_byte_t control_a_reg_q;                 // Enable and prescale select
  tbc_byte_t ctrlb_q;                 // Transfer point and split
  tbc_byte_t control_e_reg_q;                 // Direction and hold
  tbc_byte_t event_control_reg_q;                // Event usage
  tbc_byte_t status_q;                // Sticky hit flags
  tbc_byte_t status_d;

  wire       enable   = control_a_reg_q[`TBC_A_ENABLE];
  wire [2:0] presc    = control_a_reg_q[`TBC_A_PRESC_HI:`TBC_A_PRESC_LO];
  wire       upd_peak = ctrlb_q[`TBC_B_UPD_PEAK];
  wire       split    = ctrlb_q[`TBC_B_SPLIT];
  wire       hold     = control_e_reg_q[`TBC_E_HOLD];
  wire       ev_cnt   = event_control_reg_q[`TBC_EV_COUNT_EN];
  wire       ev_dir   = event_control_reg_q[`TBC_EV_DIR_EN];
  wire       ev_rst   = event_control_reg_q[`TBC_EV_RESTART];

  // Control register writes
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      control_a_reg_q  <= `TBC_RST_BYTE;
      ctrlb_q  <= `TBC_RST_BYTE;
      control_e_reg_q  <= `TBC_RST_BYTE;
      event_control_reg_q <= `TBC_RST_BYTE;
    end else begin
      if (we_a) control_a_reg_q <= WB_DAT_I[7:0];
      if (we_b) ctrlb_q <= WB_DAT_I[7:0];
      if (we_e) control_e_reg_q <= WB_DAT_I[7:0];
      if (we_ev) event_control_reg_q <= WB_DAT_I[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick generation

  logic [6:0] pre_q;                  // Prescale divider, cleared while disabled
  // Divide by two to the power of the select field
  wire  [6:0] pre_mask = 7'((8'h01 << presc) - 8'h01);
  wire        pre_tick = (pre_q & pre_mask) == pre_mask;
  // Event input replaces the prescaled clock
  wire        tick_src = ev_cnt ? EVT_COUNT : pre_tick;
  wire        tick     = enable & tick_src;
  // Event level may override the software direction
  wire        down_sel = ev_dir ? EVT_DIR : control_e_reg_q[`TBC_E_DIR];
  tbc_dir_t   dir;
  assign dir = down_sel ? TBC_DOWN : TBC_UP;

  // Divider runs only while enabled, so the first tick comes one full prescale period after enable
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) pre_q <= 7'h00;
    else if (!enable) pre_q <= 7'h00;
    else pre_q <= pre_q + 7'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count and compare

  tbc_word_t cnt_q;
  tbc_word_t cnt_d;
  tbc_word_t wrap_q;                  // Wrap limit
  tbc_word_t wrap_d;
  tbc_word_t wbuf_q;                  // Wrap limit buffer
  logic      wbv_q;                   // Wrap limit buffer valid
  tbc_word_t match_q [3];             // Match values
  tbc_word_t mbuf_q  [3];             // Match buffers
  logic [2:0] mbv_q;                  // Match buffer valids
  logic [2:0] hit_m;                  // Full-width matches
  logic [2:0] hit_mh;                 // Upper-half matches in split

  // Fixed-point compares
  wire hit_zero = cnt_q == `TBC_ZERO_POINT;
  wire hit_peak = cnt_q == wrap_q;
  wire lo_zero  = cnt_q[7:0] == `TBC_RST_BYTE;
  wire hi_zero  = cnt_q[15:8] == `TBC_RST_BYTE;

  // Next count in one-piece mode; plain increment rolls over all-ones
  wire tbc_word_t up_next = hit_peak ? `TBC_ZERO_POINT : cnt_q + 16'h0001;
  wire tbc_word_t dn_next = hit_zero ? wrap_q : cnt_q - 16'h0001;
  wire tbc_word_t one_next = (dir == TBC_DOWN) ? dn_next : up_next;
  // Split mode: both halves count down, each reloads its own limit byte
  wire tbc_byte_t lo_next = lo_zero ? wrap_q[7:0] : cnt_q[7:0] - 8'h01;
  wire tbc_byte_t hi_next = hi_zero ? wrap_q[15:8] : cnt_q[15:8] - 8'h01;
  wire tbc_word_t step    = split ? {hi_next, lo_next} : one_next;
  // Restart event takes the counter back to its starting point
  wire restart = ev_rst & EVT_RESTART & enable;
  wire tbc_word_t start_val = (dir == TBC_DOWN || split) ? wrap_q : `TBC_ZERO_POINT;

  // Software write wins over restart, which wins over counting
  assign cnt_d = we_cnt ? tbc_merge(cnt_q, WB_DAT_I, WB_SEL_I)
               : restart ? start_val
               : tick ? step
               : cnt_q;

  // Transfer point; split mode has no buffering
  wire xfer = tick & ~split & ~hold & (upd_peak ? hit_peak : hit_zero);

  // Direct write is immediate; buffer copied only when valid
  assign wrap_d = we_wrap ? tbc_merge(wrap_q, WB_DAT_I, WB_SEL_I)
                : (xfer & wbv_q) ? wbuf_q
                : wrap_q;

  // Counter, wrap limit and its buffer
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cnt_q  <= `TBC_RST_WORD;
      wrap_q <= `TBC_RST_WRAP;
      wbuf_q <= `TBC_RST_WRAP;
      wbv_q  <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      wrap_q <= wrap_d;
      if (we_wbuf) wbuf_q <= tbc_merge(wbuf_q, WB_DAT_I, WB_SEL_I);
      // A buffer write in the transfer cycle keeps valid set
      wbv_q  <= we_wbuf | (wbv_q & ~xfer);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Match channels

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_match
      wire [7:0] ofs_m  = `TBC_OFS_MATCH + 8'(gi) * `TBC_OFS_STRIDE;
      wire [7:0] ofs_b  = `TBC_OFS_MATCHBUF + 8'(gi) * `TBC_OFS_STRIDE;
      wire       we_m   = wr & (WB_ADR_I == ofs_m);
      wire       we_mb  = wr & (WB_ADR_I == ofs_b);
      wire       take   = xfer & mbv_q[gi];
      assign hit_m[gi]  = cnt_q == match_q[gi];
      assign hit_mh[gi] = cnt_q[15:8] == match_q[gi][15:8];

      // Match value, buffer and valid flag
      always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
          match_q[gi] <= `TBC_RST_WORD;
          mbuf_q[gi]  <= `TBC_RST_WORD;
          mbv_q[gi]   <= 1'b0;
        end else begin
          if (we_m) match_q[gi] <= tbc_merge(match_q[gi], WB_DAT_I, WB_SEL_I);
          else if (take) match_q[gi] <= mbuf_q[gi];
          if (we_mb) mbuf_q[gi] <= tbc_merge(mbuf_q[gi], WB_DAT_I, WB_SEL_I);
          mbv_q[gi] <= we_mb | (mbv_q[gi] & ~xfer);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Hit events and sticky flags

  logic       peak_q;                 // Peak event pulse
  logic       zero_q;                 // Zero event pulse
  logic [2:0] mevt_q;                 // Match event pulses
  logic [2:0] mhevt_q;                // Upper-half match pulses

  // Split halves report their own underflow and matches
  wire       peak_hit = split ? hi_zero : hit_peak;
  wire       zero_hit = split ? lo_zero : hit_zero;
  wire [2:0] lo_m;
  assign lo_m[0] = cnt_q[7:0] == match_q[0][7:0];
  assign lo_m[1] = cnt_q[7:0] == match_q[1][7:0];
  assign lo_m[2] = cnt_q[7:0] == match_q[2][7:0];
  wire [2:0] m_hit  = split ? lo_m : hit_m;
  wire [2:0] mh_hit = split ? hit_mh : 3'b000;

  // Hits seen before a tick show at that tick's edge
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      peak_q  <= 1'b0;
      zero_q  <= 1'b0;
      mevt_q  <= 3'b000;
      mhevt_q <= 3'b000;
    end else begin
      peak_q  <= tick & peak_hit;
      zero_q  <= tick & zero_hit;
      mevt_q  <= {3{tick}} & m_hit;
      mhevt_q <= {3{tick}} & mh_hit;
    end
  end

  // Write one clears; a new hit in the same cycle wins
  wire [7:0] st_set = {3'b000, mevt_q, zero_q, peak_q};
  wire [7:0] st_clr = we_st ? WB_DAT_I[7:0] : 8'h00;
  assign status_d = (status_q & ~st_clr) | st_set;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) status_q <= `TBC_RST_BYTE;
    else status_q <= status_d;
  end

  assign PEAK_EVT     = peak_q;
  assign ZERO_EVT     = zero_q;
  assign MATCH_EVT    = mevt_q;
  assign MATCH_HI_EVT = mhevt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Match registers and buffers share a small index decode
  wire [7:0] m_rel  = WB_ADR_I - `TBC_OFS_MATCH;
  wire [7:0] b_rel  = WB_ADR_I - `TBC_OFS_MATCHBUF;
  wire       is_m   = (WB_ADR_I >= `TBC_OFS_MATCH) && (WB_ADR_I < `TBC_OFS_MATCHBUF) &&
                      (m_rel[1:0] == 2'b00);
  wire       is_b   = (WB_ADR_I >= `TBC_OFS_MATCHBUF) && (b_rel < 8'h0C) && (b_rel[1:0] == 2'b00);
  wire [1:0] m_idx  = m_rel[3:2];
  wire [1:0] b_idx  = b_rel[3:2];
  wire [7:0] control_f_reg  = {4'h0, mbv_q, wbv_q};

  // Unmapped offsets read as zero
  assign rd_mux = sel_a    ? {24'h00_0000, control_a_reg_q}
                : sel_b    ? {24'h00_0000, ctrlb_q}
                : sel_e    ? {24'h00_0000, control_e_reg_q}
                : sel_f    ? {24'h00_0000, control_f_reg}
                : sel_ev   ? {24'h00_0000, event_control_reg_q}
                : sel_st   ? {24'h00_0000, status_q}
                : sel_cnt  ? {16'h0000, cnt_q}
                : sel_wrap ? {16'h0000, wrap_q}
                : sel_wbuf ? {16'h0000, wbuf_q}
                : is_m     ? {16'h0000, match_q[m_idx]}
                : is_b     ? {16'h0000, mbuf_q[b_idx]}
                : `TBC_RST_BUS;

  // One wait state, then a single-cycle ack
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ack_q <= 1'b0;
      rd_q  <= `TBC_RST_BUS;
    end else begin
      ack_q <= bus_req & ~ack_q;
      if (bus_req & ~ack_q & ~WB_WE_I) rd_q <= rd_mux;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rd_q;

endmodule : tbc_timer_base_counter
`default_nettype wire
